/* File: core/card_reader_config_regs.sv */
// configuration register bank of a usb-to-sd card-reader bridge, reached over a two-wire serial bus
// assumes scl/sda/addr_sel are asynchronous pins; supplies, events and status reads are on clk
// Functional notes
// [R01] reader presents usb mass-storage class
// [R02] high speed when host capable, else full
// [R03] writable 16-bit vendor and product codes
// [R04] registers writable with only host supply
// [R05] control bit 4 closes port b switches
// [R06] control bit 3 closes port a switches
// [R07] control bits 2:1 select reader path
// [R08] control bit 0 requests micro wake
// [R09] interrupt_and_bus_config bit 7 narrows port b bus
// [R10] interrupt_and_bus_config bit 6 narrows port a bus
// [R11] interrupt level until read, or pulse
// [R12] interrupt_and_bus_config bit 4 sets interrupt polarity
// [R13] clock_and_speed_config bits 6:2 select reference input
// [R14] clock_and_speed_config bit 1 caps usb to full speed
// [R15] bits 7:4 limit port b clock
// [R16] bits 3:0 limit port a clock
// [R17] enable bits gate change events onto interrupt
// [R18] written bytes follow pointer, auto increment
// [R19] 7-bit address, low bit from pin
// [R20] reads from pointer, stop after nack
// [R21] reader path switches forced open, writes ignored
// [R22] reserved bits store and read back
// [R23] reader settings sampled at activation
`timescale 1ns/10ps
`default_nettype none
module card_reader_config_regs #(
  parameter int unsigned IRQ_PULSE_CYCLES = cfg_pkg::IRQ_PULSE_CYCLES,
  parameter logic [15:0] VENDOR_DEFAULT = 16'h1111, // arbitrary value
  parameter logic [15:0] PRODUCT_DEFAULT = 16'h2222 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // serial control bus
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_sel,
  // supplies and usb host
  input wire logic transceiver_supply_ok,
  input wire logic card_supply_ok,
  input wire logic host_hs_capable,
  // interrupt sources and pin
  input wire logic [cfg_pkg::NUM_EVENTS-1:0] change_events,
  input wire logic status_read,
  output logic irq_pin,
  // card limits reported by the cards, as log2 of divider
  input wire logic [2:0] port_a_card_div,
  input wire logic [2:0] port_b_card_div,
  // control outputs
  output logic micro_wake_request,
  output logic port_a_switch_close,
  output logic port_b_switch_close,
  output logic reader_on_port_a,
  output logic reader_on_port_b,
  output cfg_pkg::reader_cfg_t reader_cfg,
  output logic [4:0] reference_input_effective,
  output logic usb_high_speed,
  output logic [7:0] usb_class_code,
  output logic [15:0] usb_vendor_id,
  output logic [15:0] usb_product_id,
  output logic [2:0] port_a_clock_div,
  output logic [2:0] port_b_clock_div
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WR = 7'h08,
    ST_WR_ACK = 7'h10,
    ST_RD = 7'h20,
    ST_RD_ACK = 7'h40
  } bus_state_t;

  // pin synchronisation and edge finding
  logic [2:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic addr_s;
  logic scl_p_q;
  logic sda_p_q;

  pin_sync #(.W(3), .INIT(3'h3)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({addr_sel, sda_in, scl}),
    .q(pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign addr_s = pins_s[2];

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // registers
  logic [7:0] ctl_q, ctl_d;
  logic [7:0] cfg1_q, cfg1_d;
  logic [7:0] cfg2_q, cfg2_d;
  logic [7:0] lim_q, lim_d;
  logic [7:0] ie_q, ie_d;
  logic [7:0] id_q [4];
  logic [7:0] id_d [4];
  logic [3:0] id_wr_q, id_wr_d;

  // bus engine state
  bus_state_t st_q, st_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] ptr_q, ptr_d;
  logic ptr_phase_q, ptr_phase_d;
  logic rw_q, rw_d;
  logic nack_q, nack_d;
  logic drv_q, drv_d;
  logic wr_en;
  logic addr_match;

  // reader activation
  logic reader_on;
  logic active_q, active_d;
  cfg_pkg::reader_cfg_t lat_q, lat_d, live_cfg;
  logic owned_a;
  logic owned_b;

  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      cfg_pkg::REG_CONTROL: r = ctl_q;
      cfg_pkg::REG_CFG1: r = cfg1_q;
      cfg_pkg::REG_CFG2: r = cfg2_q;
      cfg_pkg::REG_CLK_LIMIT: r = lim_q;
      cfg_pkg::REG_IE_LOW: r = ie_q;
      default: begin
        if (a >= cfg_pkg::REG_VID_HI && a <= cfg_pkg::REG_PID_LO) begin
          r = id_q[2'(a - cfg_pkg::REG_VID_HI)];
        end
      end
    endcase
    return r;
  endfunction : rd_byte

  // limit code to log2 divider: 0000/0001 base, 0010..0111 /2../64
  function automatic logic [2:0] lim_div(input logic [3:0] c);
    logic [2:0] r;
    r = 3'h0;
    if (c >= 4'h2 && c <= 4'h7) begin
      r = 3'(c - 4'h1);
    end
    return r;
  endfunction : lim_div

  always_comb begin
    scl_rise = scl_s & ~scl_p_q;
    scl_fall = ~scl_s & scl_p_q;
    bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
    bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
    addr_match = (sh_q[7:1] == {cfg_pkg::BUS_ADDR_BASE, addr_s}); // [R19]
    st_d = st_q;
    sh_d = sh_q;
    tx_d = tx_q;
    cnt_d = cnt_q;
    ptr_d = ptr_q;
    ptr_phase_d = ptr_phase_q;
    rw_d = rw_q;
    nack_d = nack_q;
    drv_d = drv_q;
    wr_en = 1'b0;
    if (bus_start) begin
      st_d = ST_ADDR;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end else if (bus_stop) begin
      st_d = ST_IDLE;
      drv_d = 1'b0;
    end else if (scl_rise) begin
      sh_d = {sh_q[6:0], sda_s};
      cnt_d = cnt_q + 4'h1;
      if (st_q == ST_RD_ACK) begin
        nack_d = sda_s;
      end
    end else if (scl_fall) begin
      case (st_q)
        ST_ADDR: begin
          if (cnt_q == 4'h8) begin
            if (addr_match) begin // [R19]
              st_d = ST_ADDR_ACK;
              drv_d = 1'b1;
              rw_d = sh_q[0];
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          cnt_d = 4'h0;
          if (rw_q) begin
            st_d = ST_RD;
            tx_d = rd_byte(ptr_q); // [R20]
            drv_d = ~tx_d[7];
          end else begin
            st_d = ST_WR;
            drv_d = 1'b0;
            ptr_phase_d = 1'b1;
          end
        end
        ST_WR: begin
          if (cnt_q == 4'h8) begin
            st_d = ST_WR_ACK;
            drv_d = 1'b1;
            if (ptr_phase_q) begin
              ptr_d = sh_q;
              ptr_phase_d = 1'b0;
            end else begin
              wr_en = 1'b1;
              ptr_d = ptr_q + 8'h1; // [R18]
            end
          end
        end
        ST_WR_ACK: begin
          st_d = ST_WR;
          drv_d = 1'b0;
          cnt_d = 4'h0;
        end
        ST_RD: begin
          if (cnt_q == 4'h8) begin
            st_d = ST_RD_ACK;
            drv_d = 1'b0;
            ptr_d = ptr_q + 8'h1; // [R20]
          end else begin
            tx_d = {tx_q[6:0], 1'b0};
            drv_d = ~tx_q[6];
          end
        end
        ST_RD_ACK: begin
          cnt_d = 4'h0;
          if (nack_q) begin
            st_d = ST_IDLE; // [R20]
          end else begin
            st_d = ST_RD;
            tx_d = rd_byte(ptr_q);
            drv_d = ~tx_d[7];
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
    sda_out = 1'b0;
    sda_oe_n = ~drv_q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ST_IDLE;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      cnt_q <= 4'h0;
      ptr_q <= 8'h00;
      ptr_phase_q <= 1'b0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      drv_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      cnt_q <= cnt_d;
      ptr_q <= ptr_d;
      ptr_phase_q <= ptr_phase_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      drv_q <= drv_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // register writes need no supply beyond the bus logic itself
  always_comb begin
    ctl_d = ctl_q;
    cfg1_d = cfg1_q;
    cfg2_d = cfg2_q;
    lim_d = lim_q;
    ie_d = ie_q;
    id_d = id_q;
    id_wr_d = id_wr_q;
    if (wr_en) begin // [R04] [R18] [R22]
      case (ptr_q)
        cfg_pkg::REG_CONTROL: begin
          ctl_d = sh_q;
          if (owned_a) ctl_d[cfg_pkg::CTL_PORT_A_SW] = ctl_q[cfg_pkg::CTL_PORT_A_SW]; // [R21]
          if (owned_b) ctl_d[cfg_pkg::CTL_PORT_B_SW] = ctl_q[cfg_pkg::CTL_PORT_B_SW]; // [R21]
        end
        cfg_pkg::REG_CFG1: cfg1_d = sh_q;
        cfg_pkg::REG_CFG2: cfg2_d = sh_q;
        cfg_pkg::REG_CLK_LIMIT: lim_d = sh_q;
        cfg_pkg::REG_IE_LOW: ie_d = sh_q;
        default: begin
          if (ptr_q >= cfg_pkg::REG_VID_HI && ptr_q <= cfg_pkg::REG_PID_LO) begin
            id_d[2'(ptr_q - cfg_pkg::REG_VID_HI)] = sh_q; // [R03]
            id_wr_d[2'(ptr_q - cfg_pkg::REG_VID_HI)] = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q <= cfg_pkg::CONTROL_RESET; // [R05] [R06] [R07] [R08]
      cfg1_q <= cfg_pkg::ZERO_RESET;
      cfg2_q <= cfg_pkg::ZERO_RESET;
      lim_q <= cfg_pkg::ZERO_RESET;
      ie_q <= cfg_pkg::ZERO_RESET;
      id_q <= '{default: 8'h00};
      id_wr_q <= 4'h0;
    end else begin
      ctl_q <= ctl_d;
      cfg1_q <= cfg1_d;
      cfg2_q <= cfg2_d;
      lim_q <= lim_d;
      ie_q <= ie_d;
      id_q <= id_d;
      id_wr_q <= id_wr_d;
    end
  end

  // reader activation and frozen settings
  always_comb begin
    live_cfg.port_b_narrow_bus = cfg1_q[cfg_pkg::CFG1_PORT_B_NARROW]; // [R09]
    live_cfg.port_a_narrow_bus = cfg1_q[cfg_pkg::CFG1_PORT_A_NARROW]; // [R10]
    live_cfg.reference_input_select = cfg2_q[cfg_pkg::CFG2_REF_LO +: 5]; // [R13]
    live_cfg.usb_speed_cap = cfg2_q[cfg_pkg::CFG2_SPEED_CAP]; // [R14]
    live_cfg.port_b_clock_limit = lim_q[cfg_pkg::LIM_PORT_B_LO +: 4]; // [R15]
    live_cfg.port_a_clock_limit = lim_q[cfg_pkg::LIM_PORT_A_LO +: 4]; // [R16]
    reader_on = ctl_q[cfg_pkg::CTL_WAKE] & transceiver_supply_ok & card_supply_ok &
                (ctl_q[2:1] == cfg_pkg::MODE_PORT_A || ctl_q[2:1] == cfg_pkg::MODE_PORT_B); // [R07] [R04]
    active_d = reader_on;
    lat_d = (reader_on && !active_q) ? live_cfg : lat_q; // [R23]
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      active_q <= 1'b0;
      lat_q <= '0;
    end else begin
      active_q <= active_d;
      lat_q <= lat_d;
    end
  end

  always_comb begin
    owned_a = active_q & (ctl_q[2:1] == cfg_pkg::MODE_PORT_A);
    owned_b = active_q & (ctl_q[2:1] == cfg_pkg::MODE_PORT_B);
    reader_on_port_a = owned_a; // [R07]
    reader_on_port_b = owned_b;
    micro_wake_request = ctl_q[cfg_pkg::CTL_WAKE]; // [R08]
    port_a_switch_close = ctl_q[cfg_pkg::CTL_PORT_A_SW] & ~owned_a; // [R06] [R21]
    port_b_switch_close = ctl_q[cfg_pkg::CTL_PORT_B_SW] & ~owned_b; // [R05] [R21]
    reader_cfg = lat_q;
    // undocumented codes fall back to the default source
    reference_input_effective = (!lat_q.reference_input_select[4] &&
      (lat_q.reference_input_select[1:0] == 2'h1 || lat_q.reference_input_select[1:0] == 2'h2)) ?
      lat_q.reference_input_select : 5'h00; // [R13]
    usb_high_speed = active_q & host_hs_capable & ~lat_q.usb_speed_cap; // [R02] [R14]
    usb_class_code = cfg_pkg::USB_CLASS_MASS_STORAGE; // [R01]
    usb_vendor_id[15:8] = id_wr_q[0] ? id_q[0] : VENDOR_DEFAULT[15:8]; // [R03]
    usb_vendor_id[7:0] = id_wr_q[1] ? id_q[1] : VENDOR_DEFAULT[7:0];
    usb_product_id[15:8] = id_wr_q[2] ? id_q[2] : PRODUCT_DEFAULT[15:8];
    usb_product_id[7:0] = id_wr_q[3] ? id_q[3] : PRODUCT_DEFAULT[7:0];
    // the slower of programmed limit and card maximum wins
    port_a_clock_div = lim_div(lat_q.port_a_clock_limit) > port_a_card_div ?
      lim_div(lat_q.port_a_clock_limit) : port_a_card_div; // [R16]
    port_b_clock_div = lim_div(lat_q.port_b_clock_limit) > port_b_card_div ?
      lim_div(lat_q.port_b_clock_limit) : port_b_card_div; // [R15]
  end

  irq_output #(.PULSE_CYCLES(IRQ_PULSE_CYCLES)) u_irq (
    .clk(clk),
    .reset_n(reset_n),
    .events(change_events),
    .enables(ie_q[cfg_pkg::IE_EVENT_LO +: cfg_pkg::NUM_EVENTS]), // [R17]
    .pulse_style(cfg1_q[cfg_pkg::CFG1_IRQ_PULSE]),
    .polarity_high(cfg1_q[cfg_pkg::CFG1_IRQ_POL_HIGH]),
    .status_read(status_read),
    .irq_pin(irq_pin)
  );

  a_switch_owned_open: assert property (@(posedge clk) disable iff (!reset_n)
    (owned_a |-> !port_a_switch_close) and (owned_b |-> !port_b_switch_close)) // [R21]
    else $error("reader path switch not held open");
  a_ptr_data_advance: assert property (@(posedge clk) disable iff (!reset_n)
    wr_en |=> ptr_q == $past(ptr_q) + 8'h1) // [R18]
    else $error("pointer did not advance after data byte");
  a_addr_ack_match: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q == ST_ADDR && st_d == ST_ADDR_ACK) |-> sh_q[7:1] == {cfg_pkg::BUS_ADDR_BASE, addr_s}) // [R19]
    else $error("acknowledged a foreign address");
  a_cfg_frozen: assert property (@(posedge clk) disable iff (!reset_n)
    (active_q && $past(active_q)) |-> $stable(lat_q)) // [R23]
    else $error("reader settings changed while active");
  a_speed_cap: assert property (@(posedge clk) disable iff (!reset_n)
    usb_high_speed |-> (!lat_q.usb_speed_cap && host_hs_capable)) // [R02]
    else $error("high speed despite cap or full-speed host");
  a_mode_wake: assert property (@(posedge clk) disable iff (!reset_n)
    reader_on |-> (ctl_q[cfg_pkg::CTL_WAKE] && ctl_q[2] != ctl_q[1])) // [R07]
    else $error("reader active without wake or valid path");
  a_read_nack_stop: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q == ST_RD_ACK && nack_q && scl_fall && !bus_start && !bus_stop) |=> (st_q == ST_IDLE) && !drv_q) // [R20]
    else $error("data driven after nack");
  a_clock_div_range: assert property (@(posedge clk) disable iff (!reset_n)
    (port_a_clock_div >= port_a_card_div) && (port_b_clock_div >= port_b_card_div)) // [R16]
    else $error("card clock faster than card maximum");
endmodule : card_reader_config_regs
`default_nettype wire

/* File: core/cfg_pkg.sv */
// shared constants and types for the card-reader configuration register bank
// assumes a 100 MHz core clock and a byte-wide serial control bus
package cfg_pkg;

  // register offsets
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_CFG1 = 8'h01;
  localparam logic [7:0] REG_CFG2 = 8'h02;
  localparam logic [7:0] REG_CLK_LIMIT = 8'h03;
  localparam logic [7:0] REG_IE_LOW = 8'h04;
  localparam logic [7:0] REG_VID_HI = 8'h06;
  localparam logic [7:0] REG_PID_LO = 8'h09;

  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h18;
  localparam logic [7:0] ZERO_RESET = 8'h00;

  // field positions
  localparam int CTL_WAKE = 0;
  localparam int CTL_MODE_LO = 1;
  localparam int CTL_PORT_A_SW = 3;
  localparam int CTL_PORT_B_SW = 4;
  localparam int CFG1_PORT_B_NARROW = 7;
  localparam int CFG1_PORT_A_NARROW = 6;
  localparam int CFG1_IRQ_PULSE = 5;
  localparam int CFG1_IRQ_POL_HIGH = 4;
  localparam int CFG2_REF_LO = 2;
  localparam int CFG2_SPEED_CAP = 1;
  localparam int LIM_PORT_B_LO = 4;
  localparam int LIM_PORT_A_LO = 0;
  localparam int IE_EVENT_LO = 2;
  localparam int NUM_EVENTS = 5;

  // reader path codes
  localparam logic [1:0] MODE_PORT_A = 2'h1;
  localparam logic [1:0] MODE_PORT_B = 2'h2;

  // upper six bits of the 7-bit bus address; the low bit follows a pin
  localparam logic [5:0] BUS_ADDR_BASE = 6'h38;

  // usb mass-storage class code
  localparam logic [7:0] USB_CLASS_MASS_STORAGE = 8'h08;

  // interrupt pulse width
  localparam int IRQ_PULSE_MS = 10;
  localparam int CLK_KHZ = 100000;
  localparam int IRQ_PULSE_CYCLES = IRQ_PULSE_MS * CLK_KHZ;

  // settings frozen when card-reader operation begins
  typedef struct packed {
    logic port_b_narrow_bus;
    logic port_a_narrow_bus;
    logic [4:0] reference_input_select;
    logic usb_speed_cap;
    logic [3:0] port_b_clock_limit;
    logic [3:0] port_a_clock_limit;
  } reader_cfg_t;

endpackage : cfg_pkg

/* File: core/irq_output.sv */
// interrupt pin driver: sticky pending bits, level or timed pulse, programmable polarity
// assumes events are one-cycle pulses on clk
`timescale 1ns/10ps
`default_nettype none
module irq_output #(
  parameter int unsigned PULSE_CYCLES = cfg_pkg::IRQ_PULSE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // events and control
  input wire logic [cfg_pkg::NUM_EVENTS-1:0] events,
  input wire logic [cfg_pkg::NUM_EVENTS-1:0] enables,
  input wire logic pulse_style,
  input wire logic polarity_high,
  input wire logic status_read,
  // pin
  output logic irq_pin
);
  logic [cfg_pkg::NUM_EVENTS-1:0] pend_q;
  logic [cfg_pkg::NUM_EVENTS-1:0] pend_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic active;
  logic fresh;

  always_comb begin
    fresh = |(events & enables);
    // a new event wins over a clear in the same cycle
    pend_d = (status_read ? '0 : pend_q) | (events & enables); // [R17]
    cnt_d = cnt_q;
    if (fresh) begin
      cnt_d = PULSE_CYCLES;
    end else if (cnt_q != 32'h0) begin
      cnt_d = cnt_q - 32'h1;
    end
    active = pulse_style ? (cnt_q != 32'h0) : (|pend_q); // [R11]
    irq_pin = polarity_high ? active : ~active; // [R12]
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_q <= '0;
      cnt_q <= 32'h0;
    end else begin
      pend_q <= pend_d;
      cnt_q <= cnt_d;
    end
  end

  a_irq_pulse_len: assert property (@(posedge clk) disable iff (!reset_n)
    (pulse_style && fresh) |=> (cnt_q == PULSE_CYCLES) && active) // [R11]
    else $error("interrupt pulse not started at full length");
  a_irq_level_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (!pulse_style && (|pend_q) && !status_read) |=> active) // [R11]
    else $error("level interrupt dropped before status read");
  a_irq_polarity: assert property (@(posedge clk) disable iff (!reset_n)
    active |-> (irq_pin == polarity_high)) // [R12]
    else $error("interrupt pin polarity wrong");
endmodule : irq_output
`default_nettype wire

/* File: core/pin_sync.sv */
// two-flop synchroniser for a group of pins
// assumes the inputs are asynchronous to clk
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = d;
    q_d = meta_q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end
endmodule : pin_sync
`default_nettype wire

/* File: core/pin_sync_unused_guard.sv */
// holds no logic; synchronisation of pins is done by pin_sync

/* File: testbench/bus_host_model.sv */
// two-wire serial bus master standing in for the host processor
// assumes the bench ands sda_m with the device's open-drain pull on a wire with pull-up
`timescale 1ns/10ps
`default_nettype none
module bus_host_model (
  // clock
  input wire logic clk,
  // bus
  input wire logic sda,
  input wire logic addr_bit,
  output logic scl,
  output logic sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w
  // sda only moves while scl is low, so no false start or stop
  task automatic bx(input logic b, output logic r);
    w(2);
    sda_m = b;
    w(2);
    scl = 1'b1;
    w(4);
    r = sda;
    scl = 1'b0;
  endtask : bx
  task automatic start();
    w(2);
    sda_m = 1'b1;
    w(2);
    scl = 1'b1;
    w(4);
    sda_m = 1'b0;
    w(4);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    w(2);
    sda_m = 1'b0;
    w(2);
    scl = 1'b1;
    w(4);
    sda_m = 1'b1;
    w(4);
  endtask : stop
  task automatic xb(input logic [7:0] tx, input logic ain, output logic [7:0] rx, output logic aout);
    for (int i = 7; i >= 0; i--) begin
      bx(tx[i], rx[i]);
    end
    bx(ain, aout);
  endtask : xb
  task automatic wr(input logic [7:0] p, input logic [39:0] d, input int n, output logic ok);
    logic [7:0] rx;
    logic a;
    start();
    xb({cfg_pkg::BUS_ADDR_BASE, addr_bit, 1'b0}, 1'b1, rx, a);
    ok = ~a;
    xb(p, 1'b1, rx, a);
    ok &= ~a;
    for (int k = 0; k < n; k++) begin
      xb(d[8*(n-1-k) +: 8], 1'b1, rx, a);
      ok &= ~a;
    end
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] p, input int n, output logic [39:0] d, output logic ok);
    logic [7:0] rx;
    logic a;
    wr(p, 40'h0, 0, ok);
    start();
    xb({cfg_pkg::BUS_ADDR_BASE, addr_bit, 1'b1}, 1'b1, rx, a);
    ok &= ~a;
    d = '0;
    for (int k = 0; k < n; k++) begin
      xb(8'hff, k == n - 1, rx, a);
      d = {d[31:0], rx};
    end
    stop();
  endtask : rd
endmodule : bus_host_model
`default_nettype wire

/* File: testbench/card_reader_config_regs_tb_top.sv */
// self-checking bench for the configuration register bank
// assumes the bus host model drives scl/sda at an 80 ns bit period
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module card_reader_config_regs_tb_top;
  logic clk, reset_n, addr_sel, ts_ok, cs_ok, hs_cap, status_read;
  logic [4:0] change_events;
  logic [2:0] a_div, b_div;
  wire logic scl, sda_m, sda_out, sda_oe_n, irq_pin, wake, a_sw, b_sw, on_a, on_b, usb_hs;
  wire logic [4:0] ref_eff;
  wire logic [7:0] class_code;
  wire logic [15:0] vid, pid;
  wire logic [2:0] a_clk, b_clk;
  wire cfg_pkg::reader_cfg_t rcfg;
  wire logic sda_line;
  int fails = 0;
  int comparisons = 0;
  logic [1:0] modes [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
  assign sda_line = sda_m & (sda_oe_n | sda_out);
  card_reader_config_regs #(.IRQ_PULSE_CYCLES(20)) i_dut (
    .clk(clk), .reset_n(reset_n), .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_sel(addr_sel), .transceiver_supply_ok(ts_ok), .card_supply_ok(cs_ok), .host_hs_capable(hs_cap),
    .change_events(change_events), .status_read(status_read), .irq_pin(irq_pin),
    .port_a_card_div(a_div), .port_b_card_div(b_div), .micro_wake_request(wake),
    .port_a_switch_close(a_sw), .port_b_switch_close(b_sw), .reader_on_port_a(on_a), .reader_on_port_b(on_b),
    .reader_cfg(rcfg), .reference_input_effective(ref_eff), .usb_high_speed(usb_hs), .usb_class_code(class_code),
    .usb_vendor_id(vid), .usb_product_id(pid), .port_a_clock_div(a_clk), .port_b_clock_div(b_clk));
  bus_host_model i_host (.clk(clk), .sda(sda_line), .addr_bit(addr_sel), .scl(scl), .sda_m(sda_m));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [7:0] p, input logic [39:0] d, input int n);
    logic ok;
    i_host.wr(p, d, n, ok);
    `CHK(ok, 1'b1)
  endtask : wr
  task automatic rdc(input logic [7:0] p, input int n, input logic [39:0] e);
    logic ok;
    logic [39:0] d;
    i_host.rd(p, n, d, ok);
    `CHK({ok, d}, {1'b1, e})
  endtask : rdc
  task automatic pulse(input logic [4:0] e, input logic s);
    @(posedge clk) #1;
    change_events = e;
    status_read = s;
    @(posedge clk) #1;
    change_events = '0;
    status_read = 1'b0;
  endtask : pulse
  initial begin
    logic [7:0] rx;
    logic a;
    {reset_n, addr_sel, ts_ok, cs_ok, status_read, change_events, b_div} = '0;
    hs_cap = 1'b1;
    a_div = 3'h3;
    repeat (12) @(posedge clk);
    #1 reset_n = 1'b1;
    i_host.w(4);
    `CHK({wake, a_sw, b_sw, on_a, on_b, irq_pin}, 6'b011001)
    `CHK({class_code, vid, pid}, {8'h08, 16'h1111, 16'h2222})
    rdc(8'h00, 5, 40'h18_0000_0000);
    wr(8'h01, 40'h4f_85_73_84, 4);
    rdc(8'h01, 4, 40'h4f_85_73_84);
    wr(8'h05, 40'ha5, 1);
    rdc(8'h05, 1, 40'h0);
    i_host.start();
    i_host.xb(8'hc0, 1'b1, rx, a);
    i_host.stop();
    `CHK(a, 1'b1)
    addr_sel = 1'b1;
    wr(8'h00, 40'h00, 1);
    i_host.w(6);
    `CHK({wake, a_sw, b_sw}, 3'b000)
    wr(8'h00, 40'h1b, 1);
    i_host.w(6);
    `CHK({wake, on_a, a_sw, b_sw}, 4'b1011)
    {ts_ok, cs_ok} = 2'b11;
    i_host.w(6);
    `CHK({on_a, on_b, a_sw, b_sw, usb_hs, ref_eff}, {5'b10011, 5'h01})
    `CHK(rcfg, {2'b01, 5'h01, 1'b0, 4'h7, 4'h3})
    `CHK({a_clk, b_clk}, {3'h3, 3'h6})
    hs_cap = 1'b0;
    a_div = 3'h1;
    b_div = 3'h7;
    i_host.w(1);
    `CHK({usb_hs, a_clk, b_clk}, {1'b0, 3'h2, 3'h7})
    hs_cap = 1'b1;
    wr(8'h02, 40'h0e, 1);
    wr(8'h00, 40'h03, 1);
    i_host.w(6);
    `CHK({rcfg.usb_speed_cap, ref_eff, a_sw, b_sw}, {1'b0, 5'h01, 2'b00})
    rdc(8'h00, 1, 40'h0b);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, {37'h0, modes[i], 1'b1}, 1);
      i_host.w(6);
      `CHK({on_a, on_b}, {modes[i] == 2'h1, modes[i] == 2'h2})
    end
    `CHK({usb_hs, ref_eff, a_sw, b_sw}, {1'b0, 5'h00, 2'b00})
    pulse(5'h02, 1'b0);
    `CHK(irq_pin, 1'b1)
    pulse(5'h01, 1'b0);
    i_host.w(5);
    `CHK(irq_pin, 1'b0)
    pulse(5'h00, 1'b1);
    `CHK(irq_pin, 1'b1)
    wr(8'h01, 40'h3f, 1);
    `CHK(irq_pin, 1'b0)
    pulse(5'h01, 1'b0);
    i_host.w(17);
    `CHK(irq_pin, 1'b1)
    i_host.w(6);
    `CHK(irq_pin, 1'b0)
    wr(8'h06, 40'h12_34_56_78, 4);
    i_host.w(2);
    `CHK({vid, pid}, 32'h1234_5678)
    print_verdict();
  end
  initial begin
    #200us;
    fails++;
    print_verdict();
  end
endmodule : card_reader_config_regs_tb_top
`default_nettype wire
